/* File: rtl/bmpc_params.svh */
// Behaviour
// - Hysteretic pulse starts low limit, ends high limit
// - Both drives off between hysteretic pulses
// - Forced continuous select high keeps PWM only
// - Sample phase once per cycle, before high-side
// - Phase comparator low means negative phase
// - Eight positive samples move PWM to hysteretic
// - Entering hysteretic turns both drives off
// - Eight negative samples return hysteretic to PWM
// - Below hysteretic level gives PWM next cycle
// - Low-side waits for high-side gate below 1V
// - High-side waits for low-side gate below 1V
// - Enable low keeps output off, no switching
// - Track ramp to 0.9V, then regulate
// - Power-good needs soft start done, in window
// - Undervoltage after soft start latches off
// - Overvoltage forces high off, low on
// - Crowbar held until output back in window
`ifndef BMPC_PARAMS_SVH
`define BMPC_PARAMS_SVH

// System clock
`define BMPC_CLK_PERIOD_NS 10
// Switching period at 300 kHz, in ns
`define BMPC_SW_PERIOD_NS 3333
// Switching period in system clock cycles
`define BMPC_SW_CYCLES (`BMPC_SW_PERIOD_NS / `BMPC_CLK_PERIOD_NS)
// Consecutive samples needed for a mode change
`define BMPC_MODE_RUN_LEN 8
// Number of synchronised input bits
`define BMPC_SYNC_BITS 13

// Bit positions inside the synchronised input vector
`define BMPC_IN_ENABLE 0
`define BMPC_IN_FCS 1
`define BMPC_IN_PHASE 2
`define BMPC_IN_HYST_LOW 3
`define BMPC_IN_HYST_HIGH 4
`define BMPC_IN_HYST_REG_LOW 5
`define BMPC_IN_PWM_DEMAND 6
`define BMPC_IN_HS_GATE_LOW 7
`define BMPC_IN_LS_GATE_LOW 8
`define BMPC_IN_RAMP_TARGET 9
`define BMPC_IN_WINDOW 10
`define BMPC_IN_UNDER 11
`define BMPC_IN_OVER 12

`endif

/* File: rtl/bmpc_pkg.sv */
package bmpc_pkg;

  // Converter operating mode
  typedef enum logic {
    BMPC_MODE_PWM = 1'b0,
    BMPC_MODE_HYST = 1'b1
  } bmpc_mode_type;

  // Soft-start and protection sequence, Gray along the usual path
  typedef enum logic [2:0] {
    BMPC_SS_OFF = 3'h0,
    BMPC_SS_RAMP = 3'h1,
    BMPC_SS_REG = 3'h3,
    BMPC_SS_DONE = 3'h2,
    BMPC_SS_LATCH = 3'h6
  } bmpc_ss_type;

  // Whole state of the controller
  typedef struct packed {
    logic [15:0] tick_cnt;
    bmpc_mode_type mode;
    logic [3:0] run_cnt;
    bmpc_ss_type ss;
    logic crowbar;
    logic hyst_pulse;
    logic hs_drive;
    logic ls_drive;
    logic output_in_window_flag;
    logic ramp_track;
    logic regulate;
    logic latched;
  } bmpc_state_type;

endpackage

/* File: rtl/bmpc_sync.sv */
`timescale 1ns/100ps
`include "bmpc_params.svh"

module bmpc_sync
  import bmpc_pkg::*;
#(
  parameter int WIDTH = `BMPC_SYNC_BITS
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Asynchronous inputs and their filtered copies
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] out;
  } bmpc_sync_state_type;

  bmpc_sync_state_type state_reg;
  bmpc_sync_state_type state_next;
  logic [WIDTH-1:0] out_next;

  // A change counts only once the second and third stages agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign out_next[i] = (state_reg.ff2[i] == state_reg.ff3[i]) ? state_reg.ff3[i] :
                         state_reg.out[i];
  end

  always_comb begin
    state_next = state_reg;
    state_next.ff1 = async_i;
    state_next.ff2 = state_reg.ff1;
    state_next.ff3 = state_reg.ff2;
    state_next.out = out_next;
  end

  // One register process, so every stage has a single driver
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.out;

endmodule

/* File: rtl/bmpc_top.sv */
`timescale 1ns/100ps
`include "bmpc_params.svh"

module bmpc_top
  import bmpc_pkg::*;
#(
  parameter int SW_CYCLES = `BMPC_SW_CYCLES,
  parameter int RUN_LEN = `BMPC_MODE_RUN_LEN
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Enable and mode select pins
  input wire logic enable_i,
  input wire logic forced_continuous_select_i,
  // Phase and hysteretic comparators
  input wire logic phase_cmp_i,
  input wire logic hyst_low_i,
  input wire logic hyst_high_i,
  input wire logic hyst_reg_low_i,
  // PWM modulator demand, high asks for the high-side switch
  input wire logic pwm_demand_i,
  // Gate-to-source detectors, high when below about 1V
  input wire logic hs_gate_low_i,
  input wire logic ls_gate_low_i,
  // Soft-start and output monitors
  input wire logic ramp_at_target_i,
  input wire logic in_window_i,
  input wire logic under_volt_i,
  input wire logic over_volt_i,
  // Switch drives
  output logic hs_drive_o,
  output logic ls_drive_o,
  // Status
  output logic output_in_window_flag_o,
  output logic ramp_track_o,
  output logic regulate_o,
  output logic hyst_mode_o,
  output logic latched_off_o,
  output logic crowbar_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  // The tick counter is 16 bits wide, so SW_CYCLES must not exceed 65536
  localparam logic [15:0] TICK_LAST = 16'(SW_CYCLES - 1);
  localparam logic [3:0] RUN_LAST = 4'(RUN_LEN - 1);

  logic [`BMPC_SYNC_BITS-1:0] raw_in;
  logic [`BMPC_SYNC_BITS-1:0] syn_in;

  assign raw_in[`BMPC_IN_ENABLE] = enable_i;
  assign raw_in[`BMPC_IN_FCS] = forced_continuous_select_i;
  assign raw_in[`BMPC_IN_PHASE] = phase_cmp_i;
  assign raw_in[`BMPC_IN_HYST_LOW] = hyst_low_i;
  assign raw_in[`BMPC_IN_HYST_HIGH] = hyst_high_i;
  assign raw_in[`BMPC_IN_HYST_REG_LOW] = hyst_reg_low_i;
  assign raw_in[`BMPC_IN_PWM_DEMAND] = pwm_demand_i;
  assign raw_in[`BMPC_IN_HS_GATE_LOW] = hs_gate_low_i;
  assign raw_in[`BMPC_IN_LS_GATE_LOW] = ls_gate_low_i;
  assign raw_in[`BMPC_IN_RAMP_TARGET] = ramp_at_target_i;
  assign raw_in[`BMPC_IN_WINDOW] = in_window_i;
  assign raw_in[`BMPC_IN_UNDER] = under_volt_i;
  assign raw_in[`BMPC_IN_OVER] = over_volt_i;

  // synchronise all inputs
  // Pin to core takes four edges: three stages and the agreeing output
  // stage; the drives and flags follow one edge later.
  bmpc_sync #(
    .WIDTH(`BMPC_SYNC_BITS)
  ) u_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i(raw_in),
    .sync_o(syn_in)
  );

  // Core copies of the filtered inputs
  logic en_s;
  logic fcs_s;
  logic phase_pos_s;
  logic hyst_low_s;
  logic hyst_high_s;
  logic hyst_reg_low_s;
  logic pwm_demand_s;
  logic hs_gate_low_s;
  logic ls_gate_low_s;
  logic ramp_target_s;
  logic window_s;
  logic under_s;
  logic over_s;

  assign en_s = syn_in[`BMPC_IN_ENABLE];
  assign fcs_s = syn_in[`BMPC_IN_FCS];
  assign phase_pos_s = syn_in[`BMPC_IN_PHASE];
  assign hyst_low_s = syn_in[`BMPC_IN_HYST_LOW];
  assign hyst_high_s = syn_in[`BMPC_IN_HYST_HIGH];
  assign hyst_reg_low_s = syn_in[`BMPC_IN_HYST_REG_LOW];
  assign pwm_demand_s = syn_in[`BMPC_IN_PWM_DEMAND];
  assign hs_gate_low_s = syn_in[`BMPC_IN_HS_GATE_LOW];
  assign ls_gate_low_s = syn_in[`BMPC_IN_LS_GATE_LOW];
  assign ramp_target_s = syn_in[`BMPC_IN_RAMP_TARGET];
  assign window_s = syn_in[`BMPC_IN_WINDOW];
  assign under_s = syn_in[`BMPC_IN_UNDER];
  assign over_s = syn_in[`BMPC_IN_OVER];

  ////////////////////////////////////////////////////////////////////////////
  // State

  bmpc_state_type state_reg;
  bmpc_state_type state_next;

  logic tick;
  logic active;
  logic sample;
  logic want_hs;
  logic want_ls;

  // Switching-cycle boundary, one system cycle wide
  assign tick = (state_reg.tick_cnt == TICK_LAST);

  // Converter may switch only while enabled and not latched off
  // Latch-off is left only through enable low or reset
  assign active = en_s &&
                  (state_reg.ss != BMPC_SS_OFF) &&
                  (state_reg.ss != BMPC_SS_LATCH);

  // sample at cycle end after low-side conduction
  // In hysteretic mode the low side stays off outside crowbar, so every tick counts
  assign sample = tick && active &&
                  ((state_reg.mode == BMPC_MODE_HYST) || state_reg.ls_drive);

  ////////////////////////////////////////////////////////////////////////////
  // Drive requests
  // Requests only; the dead-time gating in the next-state logic decides

  always_comb begin
    want_hs = 1'b0;
    want_ls = 1'b0;
    if (!active) begin
      want_hs = 1'b0;
      want_ls = 1'b0;
    end else if (state_reg.crowbar) begin
      // crowbar holds high off, low on
      want_hs = 1'b0;
      want_ls = 1'b1;
    end else if (state_reg.mode == BMPC_MODE_PWM) begin
      want_hs = pwm_demand_s;
      want_ls = !pwm_demand_s;
    end else begin
      // low side never on in hysteretic mode outside crowbar
      want_hs = state_reg.hyst_pulse;
      want_ls = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    state_next = state_reg;

    if (tick) begin
      state_next.tick_cnt = 16'h0000;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + 16'h0001;
    end

    // Soft-start and protection sequence
    case (state_reg.ss)
      BMPC_SS_OFF: begin
        if (en_s) begin
          state_next.ss = BMPC_SS_RAMP;
        end
      end
      BMPC_SS_RAMP: begin
        // stop tracking the ramp at 0.9V
        if (ramp_target_s) begin
          state_next.ss = BMPC_SS_REG;
        end
      end
      BMPC_SS_REG: begin
        if (window_s) begin
          state_next.ss = BMPC_SS_DONE;
        end
      end
      BMPC_SS_DONE: begin
        if (under_s) begin
          state_next.ss = BMPC_SS_LATCH;
        end
      end
      BMPC_SS_LATCH: begin
        state_next.ss = BMPC_SS_LATCH;
      end
      default: begin
        state_next.ss = BMPC_SS_OFF;
      end
    endcase
    if (!en_s) begin
      state_next.ss = BMPC_SS_OFF;
    end

    state_next.ramp_track = (state_next.ss == BMPC_SS_RAMP);
    state_next.regulate = (state_next.ss == BMPC_SS_REG) ||
                          (state_next.ss == BMPC_SS_DONE);
    state_next.latched = (state_next.ss == BMPC_SS_LATCH);

    // power good after soft start, in window
    // The flag drops in the edge after the output leaves the window
    state_next.output_in_window_flag = (state_next.ss == BMPC_SS_DONE) && window_s;

    // overvoltage enters crowbar; window leaves it
    // A fresh overvoltage wins over a window clear in the same cycle
    if (!active) begin
      state_next.crowbar = 1'b0;
    end else if (over_s) begin
      state_next.crowbar = 1'b1;
    end else if (state_reg.crowbar && window_s) begin
      state_next.crowbar = 1'b0;
    end

    // Mode control
    // One run counter serves both directions and restarts on every mode
    // change, so a run that straddles a change never counts twice
    if (!active) begin
      state_next.mode = BMPC_MODE_PWM;
      state_next.run_cnt = 4'h0;
      state_next.hyst_pulse = 1'b0;
    end else if (fcs_s) begin
      state_next.mode = BMPC_MODE_PWM;
      state_next.run_cnt = 4'h0;
      state_next.hyst_pulse = 1'b0;
    end else if (state_reg.mode == BMPC_MODE_PWM) begin
      if (sample) begin
        if (phase_pos_s) begin
          // eight positive samples in a row
          if (state_reg.run_cnt == RUN_LAST) begin
            state_next.mode = BMPC_MODE_HYST;
            state_next.run_cnt = 4'h0;
            // enter hysteretic with both drives off
            state_next.hyst_pulse = 1'b0;
          end else begin
            state_next.run_cnt = state_reg.run_cnt + 4'h1;
          end
        end else begin
          state_next.run_cnt = 4'h0;
        end
      end
    end else begin
      if (hyst_reg_low_s) begin
        // sudden load step returns to PWM at once
        // An undershoot overrides both the pulse and the run counter
        state_next.mode = BMPC_MODE_PWM;
        state_next.run_cnt = 4'h0;
        state_next.hyst_pulse = 1'b0;
      end else begin
        // pulse from lower limit to upper limit
        if (!state_reg.hyst_pulse && hyst_low_s) begin
          state_next.hyst_pulse = 1'b1;
        end else if (state_reg.hyst_pulse && hyst_high_s) begin
          state_next.hyst_pulse = 1'b0;
        end
        if (sample) begin
          if (!phase_pos_s) begin
            // eight negative samples in a row
            if (state_reg.run_cnt == RUN_LAST) begin
              state_next.mode = BMPC_MODE_PWM;
              state_next.run_cnt = 4'h0;
              state_next.hyst_pulse = 1'b0;
            end else begin
              state_next.run_cnt = state_reg.run_cnt + 4'h1;
            end
          end else begin
            state_next.run_cnt = 4'h0;
          end
        end
      end
    end

    // Drives switch off at once; turn-on waits for the other gate.
    // The partner drive must also be off here, so a slow detector
    // can never let both be asserted together.
    // high side waits for low-side gate
    state_next.hs_drive = want_hs &&
                          (state_reg.hs_drive ||
                           (!state_reg.ls_drive && ls_gate_low_s));
    // low side waits for high-side gate
    state_next.ls_drive = want_ls && !want_hs &&
                          (state_reg.ls_drive ||
                           (!state_reg.hs_drive && hs_gate_low_s));

    // the edge that enters hysteretic mode also drops both drives
    // so no PWM pulse outlives the mode change
    if ((state_reg.mode == BMPC_MODE_PWM) && (state_next.mode == BMPC_MODE_HYST)) begin
      state_next.hs_drive = 1'b0;
      state_next.ls_drive = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= '{
        tick_cnt: 16'h0000,
        mode: BMPC_MODE_PWM,
        run_cnt: 4'h0,
        ss: BMPC_SS_OFF,
        crowbar: 1'b0,
        hyst_pulse: 1'b0,
        hs_drive: 1'b0,
        ls_drive: 1'b0,
        output_in_window_flag: 1'b0,
        ramp_track: 1'b0,
        regulate: 1'b0,
        latched: 1'b0
      };
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign hs_drive_o = state_reg.hs_drive;
  assign ls_drive_o = state_reg.ls_drive;
  assign output_in_window_flag_o = state_reg.output_in_window_flag;
  assign ramp_track_o = state_reg.ramp_track;
  assign regulate_o = state_reg.regulate;
  assign hyst_mode_o = state_reg.mode;
  assign latched_off_o = state_reg.latched;
  assign crowbar_o = state_reg.crowbar;

endmodule

/* File: test/bmpc_top_monitor.sv */
`timescale 1ns/100ps
module bmpc_top_monitor
  import bmpc_pkg::*;
#(
  parameter int SW_CYCLES = 10,
  parameter int RUN_LEN = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Pins
  input wire logic enable_i,
  input wire logic forced_continuous_select_i,
  // Gate detectors as the design sees them
  input wire logic hs_gate_low_i,
  input wire logic ls_gate_low_i,
  // Outputs
  input wire logic hs_drive_o,
  input wire logic ls_drive_o,
  input wire logic output_in_window_flag_o,
  input wire logic ramp_track_o,
  input wire logic regulate_o,
  input wire logic hyst_mode_o,
  input wire logic latched_off_o,
  input wire logic crowbar_o
);
  logic [3:0] off_cnt_reg;
  // Saturating count of cycles with enable low, covers the sync latency
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) off_cnt_reg <= 4'h0;
    else if (enable_i) off_cnt_reg <= 4'h0;
    else if (off_cnt_reg != 4'hf) off_cnt_reg <= off_cnt_reg + 4'h1;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  chk_no_shoot_through:
    assert property (!(hs_drive_o && ls_drive_o)) else $error("both drives on");
  chk_hs_dead_time:
    assert property ($rose(hs_drive_o) |-> $past(ls_gate_low_i, 5))
    else $error("high side on before low gate fell");
  chk_ls_dead_time:
    assert property ($rose(ls_drive_o) |-> $past(hs_gate_low_i, 5))
    else $error("low side on before high gate fell");
  chk_fcs_keeps_pwm:
    assert property ($rose(hyst_mode_o) |-> !$past(forced_continuous_select_i, 5))
    else $error("hysteretic entered while forced");
  chk_entry_drives_off:
    assert property ($rose(hyst_mode_o) |-> (!hs_drive_o && !ls_drive_o)
      ##1 (!hs_drive_o && !ls_drive_o))
    else $error("drives on at mode entry");
  chk_hyst_low_off:
    assert property (hyst_mode_o && $past(hyst_mode_o) && !crowbar_o && !$past(crowbar_o)
      |-> !ls_drive_o) else $error("low side on in hysteretic");
  chk_disabled_quiet:
    assert property (off_cnt_reg > 4'h7 |-> !hs_drive_o && !ls_drive_o && !crowbar_o
      && !latched_off_o && !output_in_window_flag_o) else $error("active while disabled");
  chk_flag_after_ramp:
    assert property (output_in_window_flag_o |-> !ramp_track_o && !latched_off_o)
    else $error("flag outside done");
  chk_ramp_or_reg:
    assert property (!(ramp_track_o && regulate_o)) else $error("ramp and regulate");
  chk_crowbar_hs_off:
    assert property (crowbar_o && $past(crowbar_o) |-> !hs_drive_o)
    else $error("high side on in crowbar");
  chk_latch_quiet:
    assert property (latched_off_o && $past(latched_off_o) && !crowbar_o
      && !$past(crowbar_o) |-> !hs_drive_o && !ls_drive_o) else $error("switching latched");
endmodule

bind bmpc_top bmpc_top_monitor #(.SW_CYCLES(SW_CYCLES), .RUN_LEN(RUN_LEN)) mon_u (
  .clock_i(clock_i), .resetn_i(resetn_i), .enable_i(enable_i),
  .forced_continuous_select_i(forced_continuous_select_i),
  .hs_gate_low_i(hs_gate_low_i), .ls_gate_low_i(ls_gate_low_i),
  .hs_drive_o(hs_drive_o), .ls_drive_o(ls_drive_o),
  .output_in_window_flag_o(output_in_window_flag_o), .ramp_track_o(ramp_track_o),
  .regulate_o(regulate_o), .hyst_mode_o(hyst_mode_o),
  .latched_off_o(latched_off_o), .crowbar_o(crowbar_o));

/* File: test/bmpc_power_stage.sv */
`timescale 1ns/100ps
module bmpc_power_stage #(
  parameter int GATE_DLY = 3
) (
  // Clock
  input wire logic clock_i,
  // Drives and load
  input wire logic hs_drive_i,
  input wire logic ls_drive_i,
  input wire logic light_load_i,
  // Detectors
  output logic hs_gate_low_o,
  output logic ls_gate_low_o,
  output logic phase_cmp_o
);
  logic [GATE_DLY-1:0] hs_hist_reg;
  logic [GATE_DLY-1:0] ls_hist_reg;
  // Gate charge takes GATE_DLY cycles to fall after the drive drops
  always_ff @(posedge clock_i) begin
    hs_hist_reg <= {hs_hist_reg[GATE_DLY-2:0], hs_drive_i};
    ls_hist_reg <= {ls_hist_reg[GATE_DLY-2:0], ls_drive_i};
  end
  assign hs_gate_low_o = !hs_drive_i && (hs_hist_reg == '0);
  assign ls_gate_low_o = !ls_drive_i && (ls_hist_reg == '0);
  // Reverse inductor current at light load shows as a positive phase
  assign phase_cmp_o = light_load_i;
endmodule

/* File: test/buck_mode_and_protection_control_bench.sv */
`timescale 1ns/100ps
module buck_mode_and_protection_control_bench;
  import bmpc_pkg::*;
  logic clock_i, resetn_i, enable_i, fcs, h_low, h_high, h_reg, dem, ramp, win, under, over;
  logic light, hs_gl, ls_gl, phase, hs, ls, flag, rtrack, reg_o, hyst, latched, crow;
  int fails, num_checks;
  logic d;
  logic [1:0] exp_pair;
  bmpc_top #(.SW_CYCLES(10), .RUN_LEN(8)) dut_u (
    .clock_i(clock_i), .resetn_i(resetn_i), .enable_i(enable_i),
    .forced_continuous_select_i(fcs), .phase_cmp_i(phase), .hyst_low_i(h_low),
    .hyst_high_i(h_high), .hyst_reg_low_i(h_reg), .pwm_demand_i(dem),
    .hs_gate_low_i(hs_gl), .ls_gate_low_i(ls_gl), .ramp_at_target_i(ramp),
    .in_window_i(win), .under_volt_i(under), .over_volt_i(over),
    .hs_drive_o(hs), .ls_drive_o(ls), .output_in_window_flag_o(flag),
    .ramp_track_o(rtrack), .regulate_o(reg_o), .hyst_mode_o(hyst),
    .latched_off_o(latched), .crowbar_o(crow));
  bmpc_power_stage #(.GATE_DLY(3)) ps_u (
    .clock_i(clock_i), .hs_drive_i(hs), .ls_drive_i(ls), .light_load_i(light),
    .hs_gate_low_o(hs_gl), .ls_gate_low_o(ls_gl), .phase_cmp_o(phase));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic check(input logic seen, input logic exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  // Expected PWM drive pair for a demand level, high side first
  function automatic logic [1:0] pwm_drive_pair(input logic demand);
    return {demand, !demand};
  endfunction
  task automatic conclude();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Whole run is under 3000 cycles of 10 ns; the watchdog waits that long
  initial begin
    #(3000 * 10);
    fails++;
    conclude();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn_i, enable_i, fcs, h_low, h_high, h_reg, dem, ramp, win, under, over, light} = '0;
    fails = 0;
    num_checks = 0;
    void'($urandom(32'hb28f3d12));
    cyc(16);
    resetn_i = 1'b1;
    repeat (40) begin
      dem = 1'($urandom_range(1, 0));
      cyc(1);
      check(hs | ls, 1'b0, "switching while off");
    end
    enable_i = 1'b1;
    cyc(8);
    check(rtrack, 1'b1, "no ramp");
    under = 1'b1;
    cyc(10);
    check(latched, 1'b0, "latched in ramp");
    under = 1'b0;
    ramp = 1'b1;
    cyc(8);
    check(reg_o, 1'b1, "no regulate");
    check(rtrack, 1'b0, "ramp after target");
    check(flag, 1'b0, "flag outside window");
    win = 1'b1;
    cyc(8);
    check(flag, 1'b1, "no flag");
    repeat (20) begin
      d = 1'($urandom_range(1, 0));
      dem = d;
      exp_pair = pwm_drive_pair(d);
      cyc(20);
      check(hs, exp_pair[1], "high drive");
      check(ls, exp_pair[0], "low drive");
    end
    dem = 1'b0;
    light = 1'b1;
    cyc(60);
    light = 1'b0;
    cyc(20);
    light = 1'b1;
    cyc(60);
    check(hyst, 1'b0, "broken run counted");
    cyc(60);
    check(hyst, 1'b1, "no hysteretic");
    check(hs | ls, 1'b0, "drives at entry");
    h_low = 1'b1;
    cyc(15);
    h_low = 1'b0;
    cyc(15);
    check(hs, 1'b1, "pulse missing");
    h_high = 1'b1;
    cyc(10);
    check(hs | ls, 1'b0, "pulse not ended");
    h_high = 1'b0;
    h_reg = 1'b1;
    cyc(7);
    check(hyst, 1'b0, "no return on undershoot");
    h_reg = 1'b0;
    cyc(120);
    light = 1'b0;
    cyc(60);
    check(hyst, 1'b1, "left too early");
    cyc(60);
    check(hyst, 1'b0, "no return to pwm");
    dem = 1'b1;
    light = 1'b1;
    cyc(150);
    check(hyst, 1'b0, "sampled without low side");
    dem = 1'b0;
    fcs = 1'b1;
    cyc(150);
    check(hyst, 1'b0, "hysteretic while forced");
    {fcs, light} = 2'b00;
    dem = 1'b1;
    cyc(20);
    over = 1'b1;
    cyc(20);
    check(crow, 1'b1, "no crowbar");
    check(ls, 1'b1, "crowbar low side");
    check(hs, 1'b0, "crowbar high side");
    over = 1'b0;
    win = 1'b0;
    cyc(20);
    check(crow, 1'b1, "crowbar released");
    win = 1'b1;
    cyc(10);
    check(crow, 1'b0, "crowbar stuck");
    under = 1'b1;
    win = 1'b0;
    cyc(10);
    check(latched, 1'b1, "no latch-off");
    under = 1'b0;
    win = 1'b1;
    cyc(20);
    check(latched, 1'b1, "latch not held");
    enable_i = 1'b0;
    cyc(10);
    check(latched, 1'b0, "latch kept when off");
    ramp = 1'b0;
    enable_i = 1'b1;
    cyc(8);
    check(rtrack, 1'b1, "no ramp on restart");
    resetn_i = 1'b0;
    cyc(2);
    check(rtrack, 1'b0, "ramp kept in reset");
    check(hs | ls, 1'b0, "switching in reset");
    resetn_i = 1'b1;
    cyc(8);
    check(rtrack, 1'b1, "no ramp after reset");
    conclude();
  end
endmodule
